// File: hdl/trr_readout.sv
// Training register readout: mode select, four pages, three return formats.
// Assumes command pins arrive already sampled on the link clock (CK) and that
// neighbouring logic supplies status and mode values on the system clock.
`timescale 1ns/1ns
`include "trr_regs.svh"

// Overview of operation
// [R1] A12:A11 pick serial, parallel or staggered
// [R2] Strobes toggle with every returned burst
// [R3] Serial: all lanes carry location, bit7 first
// [R4] Serial reads allowed on every page
// [R5] Parallel: bit7 on DQ0, held whole burst
// [R6] Parallel byte duplicated on upper byte
// [R7] Controller uses pages 1-3 only serially
// [R8] Staggered: lane n carries location n mod 4
// [R9] Staggered nibble pattern repeats every nibble
// [R10] A2 redirects reads and writes to registers
// [R11] A1:A0 page, BA1:BA0 location
// [R12] Page 0 writable, pages 1-3 read-only
// [R13] Page 0 resets to 55,33,0f,00
// [R14] Page 0 changes only by write
// [R15] Writes to pages 1-3 discarded
// [R16] Address A7..A0 stored into location bits
// [R17] Page 1 shows captured failing command
// [R18] Page 1 loc3: error flags, latency, chip
// [R19] Controller ignores unused page 1 bits
// [R20] Page 2 mirrors mode register settings
// [R21] Page 3 loc3 low bits: activate limit
// [R22] Bit 3 set means unlimited activates
// [R23] Data starts after AL plus CL plus PL
// [R24] No bus inversion on training reads
// [R25] Write data rides on A7..A0
// [R26] Status values come from neighbouring logic
// [R27] Staggered location k: lane gets (n+k) mod 4
module trr_readout
    import trr_pkg::*;
#(
    parameter int MAX_LATENCY = 64
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clkLink,
    input  wire logic        csN,
    input  wire logic        actN,
    input  wire logic        rasN,
    input  wire logic        casN,
    input  wire logic        weN,
    input  wire logic        bankGroup0,
    input  wire logic [1:0]  bankAddr,
    input  wire logic [12:0] addr,
    input  wire logic [31:0] parityLog,
    input  wire logic [31:0] modeMirror,
    input  wire logic [3:0]  activateLimit,
    input  wire logic [5:0]  readLatency,
    output logic      [15:0] dqRise,
    output logic      [15:0] dqFall,
    output logic             dqOeN,
    output logic             dqsRise,
    output logic             dqsFall,
    output logic             dqsOeN,
    output logic             dbiOutN,
    output logic             trainingMode
);

    localparam int SNAP_W = 74;

    // Snapshot of the neighbour values, carried to the link clock by a toggle handshake.
    logic [SNAP_W-1:0] sysSnap;
    logic              sysReq;
    logic [2:0]        sysAckSync;
    logic [SNAP_W-1:0] linkSnap;
    logic [2:0]        linkReqSync;
    logic              linkAck;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sysAckSync <= 3'h0;
        end else begin
            sysAckSync <= {sysAckSync[1:0], linkAck};
        end
    end

    // The snapshot only moves while no transfer is outstanding, so the link side
    // always captures a settled word.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sysSnap <= '0;
            sysReq  <= 1'b0;
        end else if (sysAckSync[2] == sysAckSync[1] && sysAckSync[2] == sysReq) begin
            sysSnap <= {readLatency, activateLimit, modeMirror, parityLog}; // [R26]
            sysReq  <= ~sysReq;
        end
    end

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            linkReqSync <= 3'h0;
            linkAck     <= 1'b0;
            linkSnap    <= '0;
        end else begin
            linkReqSync <= {linkReqSync[1:0], sysReq};
            if (linkReqSync[2] == linkReqSync[1] && linkReqSync[2] != linkAck) begin
                linkSnap <= sysSnap;
                linkAck  <= linkReqSync[2];
            end
        end
    end

    logic [31:0] pageParity;
    logic [31:0] pageMirror;
    logic [31:0] pageCapability;
    logic [5:0]  linkLatency;

    assign pageParity     = linkSnap[31:0];  // [R17] [R18]
    assign pageMirror     = linkSnap[63:32]; // [R20]
    assign pageCapability = {4'h0, linkSnap[67:64], 24'h000000}; // [R21] [R22]
    assign linkLatency    = linkSnap[73:68];

    // Command decode on the link clock.
    logic cmdMrs;
    logic cmdRead;
    logic cmdWrite;

    assign cmdMrs   = !csN && actN && !rasN && !casN && !weN;
    assign cmdRead  = !csN && actN && rasN && !casN && weN;
    assign cmdWrite = !csN && actN && rasN && !casN && !weN;

    logic [`TRR_MODE_WIDTH-1:0] modeSelect;
    logic [1:0]                 activePage;
    trr_fmt_t                   readFormat;

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            modeSelect <= `TRR_MODE_RESET;
        end else if (cmdMrs && {bankGroup0, bankAddr} == `TRR_MR_SELECT_MODE) begin
            modeSelect <= addr; // [R10] [R11] [R1]
        end
    end

    assign trainingMode = modeSelect[`TRR_MODE_ENABLE_BIT]; // [R10]
    assign activePage   = modeSelect[`TRR_MODE_PAGE_LSB +: 2]; // [R11]
    assign readFormat   = trr_fmt_t'(modeSelect[`TRR_MODE_FMT_LSB +: 2]); // [R1]

    // Page 0 training patterns.
    logic [7:0] pattern [4];

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            pattern[0] <= `TRR_PATTERN0_RESET; // [R13]
            pattern[1] <= `TRR_PATTERN1_RESET;
            pattern[2] <= `TRR_PATTERN2_RESET;
            pattern[3] <= `TRR_PATTERN3_RESET;
        end else if (cmdWrite && trainingMode && activePage == 2'h0) begin // [R12] [R14] [R15]
            pattern[bankAddr] <= addr[7:0]; // [R16] [R25]
        end
    end

    logic [31:0] pageZero;
    logic [31:0] selectedPage;

    assign pageZero = {pattern[3], pattern[2], pattern[1], pattern[0]};

    always_comb begin
        case (activePage)
            2'h0:    selectedPage = pageZero;
            2'h1:    selectedPage = pageParity;
            2'h2:    selectedPage = pageMirror;
            2'h3:    selectedPage = pageCapability;
            default: selectedPage = pageZero;
        endcase
    end

    // Lane values for one unit interval; location k sits in bits 8k+7..8k.
    function automatic logic [15:0] trr_lanes(input trr_fmt_t fmt, input logic [1:0] loc,
                                              input logic [2:0] ui, input logic [31:0] page);
        logic [15:0] lanes;
        int          lane;
        int          bitIdx;
        lanes = 16'h0000;
        for (lane = 0; lane < 16; lane++) begin
            case (fmt)
                TRR_FMT_PARALLEL:  bitIdx = 8 * int'(loc) + 7 - (lane % 8); // [R5] [R6]
                TRR_FMT_STAGGERED: bitIdx = 8 * ((lane + int'(loc)) % 4) + 7 - int'(ui); // [R8] [R9] [R27]
                default:           bitIdx = 8 * int'(loc) + 7 - int'(ui); // [R3] [R4]
            endcase
            lanes[lane] = page[bitIdx];
        end
        return lanes;
    endfunction

    // Read latency pipe: each stage holds valid, location, format and the page word
    // as it stood when the read was taken.
    logic [MAX_LATENCY-1:0] pipeValid;
    logic [1:0]             pipeLoc  [MAX_LATENCY];
    trr_fmt_t               pipeFmt  [MAX_LATENCY];
    logic [31:0]            pipePage [MAX_LATENCY];
    logic                   readTaken;
    int                     tap;

    assign readTaken = cmdRead && trainingMode;

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            pipeValid <= '0;
        end else begin
            pipeValid <= {pipeValid[MAX_LATENCY-2:0], readTaken};
        end
    end

    always_ff @(posedge clkLink) begin
        pipeLoc[0]  <= bankAddr;
        pipeFmt[0]  <= readFormat;
        pipePage[0] <= selectedPage;
        for (int i = 1; i < MAX_LATENCY; i++) begin
            pipeLoc[i]  <= pipeLoc[i-1];
            pipeFmt[i]  <= pipeFmt[i-1];
            pipePage[i] <= pipePage[i-1];
        end
    end

    // A latency of zero is treated as one; the tap fires one cycle before the first beat.
    assign tap = (linkLatency == 6'h0) ? 0 : int'(linkLatency) - 1; // [R23]

    logic burstLaunch;

    assign burstLaunch = pipeValid[tap];

    // Burst engine: four link cycles, two unit intervals per cycle.
    trr_burst_t  burstState;
    logic [1:0]  beat;
    logic [1:0]  burstLoc;
    trr_fmt_t    burstFmt;
    logic [31:0] burstPage;

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            burstState <= TRR_BURST_IDLE;
            beat       <= 2'h0;
            burstLoc   <= 2'h0;
            burstFmt   <= TRR_FMT_SERIAL;
            burstPage  <= 32'h00000000;
        end else if (burstLaunch) begin
            burstState <= TRR_BURST_ACTIVE;
            beat       <= 2'h0;
            burstLoc   <= pipeLoc[tap];
            burstFmt   <= pipeFmt[tap];
            burstPage  <= pipePage[tap];
        end else begin
            case (burstState)
                TRR_BURST_IDLE: begin
                    beat <= 2'h0;
                end
                TRR_BURST_ACTIVE: begin
                    if (beat == `TRR_BURST_BEATS) begin
                        burstState <= TRR_BURST_IDLE;
                    end
                    beat <= beat + 2'h1;
                end
                default: begin
                    burstState <= TRR_BURST_IDLE;
                end
            endcase
        end
    end

    logic [15:0] next_dqRise;
    logic [15:0] next_dqFall;
    logic [1:0]  launchLoc;
    trr_fmt_t    launchFmt;
    logic [31:0] launchPage;
    logic [1:0]  launchBeat;
    logic        driving;

    // The next beat comes from the pipe tap on a launch, else from the running burst.
    assign launchLoc  = burstLaunch ? pipeLoc[tap] : burstLoc;
    assign launchFmt  = burstLaunch ? pipeFmt[tap] : burstFmt;
    assign launchPage = burstLaunch ? pipePage[tap] : burstPage;
    assign launchBeat = burstLaunch ? 2'h0 : beat + 2'h1;
    assign driving    = burstLaunch || (burstState == TRR_BURST_ACTIVE && beat != `TRR_BURST_BEATS);

    assign next_dqRise = trr_lanes(launchFmt, launchLoc, {launchBeat, 1'b0}, launchPage);
    assign next_dqFall = trr_lanes(launchFmt, launchLoc, {launchBeat, 1'b1}, launchPage);

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            dqRise  <= 16'h0000;
            dqFall  <= 16'h0000;
            dqOeN   <= 1'b1;
            dqsRise <= 1'b0;
            dqsFall <= 1'b0;
            dqsOeN  <= 1'b1;
        end else begin
            dqRise  <= driving ? next_dqRise : 16'h0000;
            dqFall  <= driving ? next_dqFall : 16'h0000;
            dqOeN   <= ~driving;
            dqsRise <= driving; // [R2]
            dqsFall <= 1'b0;
            dqsOeN  <= ~driving; // [R2]
        end
    end

    // Inversion is never applied to training data; the flag line reads high while driving.
    assign dbiOutN = 1'b1; // [R24]

    // Checks on the link clock.
    trr_fmt_t outFmt;
    logic     startEdge;

    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            outFmt <= TRR_FMT_SERIAL;
        end else if (driving) begin
            outFmt <= launchFmt;
        end
    end

    assign startEdge = burstLaunch && (burstState == TRR_BURST_IDLE);

    sequence s_burst_out;
        !dqOeN && !dqsOeN && dqsRise && !dqsFall;
    endsequence

    sequence s_four_beats;
        s_burst_out [*4];
    endsequence

    sequence s_page0_write;
        cmdWrite && trainingMode && activePage == 2'h0;
    endsequence

    a_burst_strobes: assert property (@(posedge clkLink) disable iff (!rst_n) // [R2]
        startEdge |=> s_four_beats) else $error("burst did not drive strobes for four cycles");

    a_mode_capture: assert property (@(posedge clkLink) disable iff (!rst_n) // [R10]
        (cmdMrs && {bankGroup0, bankAddr} == 3'h3) |=> (trainingMode == $past(addr[2])
        && readFormat == trr_fmt_t'($past(addr[12:11])))) else $error("mode select not captured");

    a_pattern_write: assert property (@(posedge clkLink) disable iff (!rst_n) // [R16]
        s_page0_write |=> pattern[$past(bankAddr)] == $past(addr[7:0])) else $error("pattern not stored");

    a_readonly_pages: assert property (@(posedge clkLink) disable iff (!rst_n) // [R15]
        (cmdWrite && activePage != 2'h0) |=> $stable(pageZero)) else $error("read-only page write took effect");

    a_pattern_hold: assert property (@(posedge clkLink) disable iff (!rst_n) // [R14]
        !(cmdWrite && trainingMode) |=> $stable(pageZero)) else $error("pattern changed without a write");

    a_serial_lanes: assert property (@(posedge clkLink) disable iff (!rst_n) // [R3]
        (!dqOeN && outFmt == TRR_FMT_SERIAL) |-> (dqRise == {16{dqRise[0]}} && dqFall == {16{dqFall[0]}}))
        else $error("serial lanes differ");

    a_upper_copy: assert property (@(posedge clkLink) disable iff (!rst_n) // [R6]
        (!dqOeN && outFmt == TRR_FMT_PARALLEL) |-> (dqRise[15:8] == dqRise[7:0] && dqRise == dqFall))
        else $error("parallel upper byte differs");

    a_nibble_repeat: assert property (@(posedge clkLink) disable iff (!rst_n) // [R9]
        (!dqOeN && outFmt == TRR_FMT_STAGGERED) |-> (dqRise == {4{dqRise[3:0]}} && dqFall == {4{dqFall[3:0]}}))
        else $error("staggered nibbles differ");

    a_latency_two: assert property (@(posedge clkLink) disable iff (!rst_n) // [R23]
        (readTaken && linkLatency == 6'h2 && $stable(linkLatency)) |-> ##2 burstLaunch ##1 !dqOeN)
        else $error("read data not launched at latency");

endmodule // trr_readout

// File: include/trr_regs.svh
// Field positions, reset patterns and command codes of the training register readout.
// Assumes the command pins are sampled on the link clock by the includer.
`ifndef TRR_REGS_SVH
`define TRR_REGS_SVH

`define TRR_MODE_WIDTH      13
`define TRR_MODE_ENABLE_BIT 2
`define TRR_MODE_PAGE_LSB   0
`define TRR_MODE_FMT_LSB    11
`define TRR_MODE_RESET      13'h0000

`define TRR_MR_SELECT_MODE  3'h3

`define TRR_PATTERN0_RESET  8'h55
`define TRR_PATTERN1_RESET  8'h33
`define TRR_PATTERN2_RESET  8'h0f
`define TRR_PATTERN3_RESET  8'h00

`define TRR_BURST_BEATS     2'h3
`define TRR_LAT_WIDTH       6

`endif

// File: include/trr_pkg.sv
// Types shared by the training register readout.
// Assumes trr_regs.svh is on the include path.
package trr_pkg;
    typedef enum logic [1:0] {
        TRR_FMT_SERIAL    = 2'h0,
        TRR_FMT_PARALLEL  = 2'h1,
        TRR_FMT_STAGGERED = 2'h2,
        TRR_FMT_RESERVED  = 2'h3
    } trr_fmt_t;

    typedef enum {
        TRR_BURST_IDLE,
        TRR_BURST_ACTIVE
    } trr_burst_t;
endpackage

// File: tb/trr_ctrl_model.sv
// Controller model driving the command pins of the training register readout.
// Assumes the bench calls its tasks and supplies the link clock.
`timescale 1ns/1ns
`include "trr_regs.svh"
module trr_ctrl_model (
    input  wire logic        clkLink,
    output logic             csN,
    output logic             actN,
    output logic             rasN,
    output logic             casN,
    output logic             weN,
    output logic             bankGroup0,
    output logic [1:0]       bankAddr,
    output logic [12:0]      addr
);
    initial begin
        {csN, actN, rasN, casN, weN, bankGroup0} = 6'h3e;
        bankAddr = 2'h0;
        addr = 13'h0000;
    end
    task automatic send(input logic [2:0] rcw, input logic [2:0] bgBa, input logic [12:0] a);
        @(negedge clkLink);
        csN = 1'b0;
        {rasN, casN, weN} = rcw;
        {bankGroup0, bankAddr} = bgBa;
        addr = a;
        @(negedge clkLink);
        // Deselected pins mean nothing, so bank address and address pins are inverted rather than held; bankGroup0, rasN, casN and weN keep their value.
        csN = 1'b1;
        bankAddr = ~bgBa[1:0];
        addr = ~a;
    endtask
    task automatic setMode(input logic [1:0] fmt, input logic en, input logic [1:0] page);
        if (fmt == 2'h3 || page != 2'h0) begin
            fmt = 2'h0;
        end
        send(3'h0, `TRR_MR_SELECT_MODE, {fmt, 8'h00, en, page});
    endtask
    task automatic writeLoc(input logic [1:0] loc, input logic [7:0] data);
        send(3'h4, {1'b0, loc}, {5'h00, data});
    endtask
    task automatic readLoc(input logic [1:0] loc);
        send(3'h5, {1'b0, loc}, 13'h0000);
    endtask
endmodule // trr_ctrl_model

// File: tb/test_training_register_readout.sv
// Self-checking bench of the training register readout with random neighbour values.
// Assumes trr_regs.svh on the include path and trr_ctrl_model on the command pins.
`timescale 1ns/1ns
`include "trr_regs.svh"
module test_training_register_readout import trr_pkg::*; ;
    logic        clk_sys, rst_n, clkLink;
    logic        csN, actN, rasN, casN, weN, bankGroup0;
    logic [1:0]  bankAddr;
    logic [12:0] addr;
    logic [31:0] parityLog, modeMirror;
    logic [3:0]  activateLimit;
    logic [5:0]  readLatency;
    logic [15:0] dqRise, dqFall;
    logic        dqOeN, dqsRise, dqsFall, dqsOeN, dbiOutN, trainingMode;
    logic [7:0]  pat [4];
    logic [7:0]  d;
    logic [1:0]  loc;
    int          miscompares, compares, lat;

    trr_ctrl_model ctrl (.clkLink(clkLink), .csN(csN), .actN(actN), .rasN(rasN), .casN(casN),
        .weN(weN), .bankGroup0(bankGroup0), .bankAddr(bankAddr), .addr(addr));
    trr_readout #(.MAX_LATENCY(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkLink(clkLink),
        .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN), .bankGroup0(bankGroup0),
        .bankAddr(bankAddr), .addr(addr), .parityLog(parityLog), .modeMirror(modeMirror),
        .activateLimit(activateLimit), .readLatency(readLatency), .dqRise(dqRise),
        .dqFall(dqFall), .dqOeN(dqOeN), .dqsRise(dqsRise), .dqsFall(dqsFall),
        .dqsOeN(dqsOeN), .dbiOutN(dbiOutN), .trainingMode(trainingMode));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // The link clock starts off phase so no edge of it lines up with the system clock.
    initial begin
        clkLink = 1'b0;
        #7;
        forever #40 clkLink = ~clkLink;
    end

    task automatic final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] locVal(input logic [1:0] page, input logic [1:0] k);
        case (page)
            2'h0: return pat[k];
            2'h1: return parityLog[8*k +: 8];
            2'h2: return modeMirror[8*k +: 8];
            default: return (k == 2'h3) ? {4'h0, activateLimit} : 8'h00;
        endcase
    endfunction
    function automatic logic [15:0] expLanes(input logic [1:0] fmt, input logic [1:0] page,
                                             input logic [1:0] k, input int ui);
        logic [15:0] r;
        logic [7:0]  v;
        for (int n = 0; n < 16; n++) begin
            v = (fmt == TRR_FMT_STAGGERED) ? locVal(page, 2'(n + k)) : locVal(page, k);
            r[n] = (fmt == TRR_FMT_PARALLEL) ? v[7 - (n % 8)] : v[7 - ui];
        end
        return r;
    endfunction
    task automatic readCheck(input logic [1:0] fmt, input logic [1:0] page, input logic [1:0] k);
        ctrl.readLoc(k);
        repeat (lat) @(negedge clkLink);
        for (int b = 0; b < 4; b++) begin
            check(dqRise, expLanes(fmt, page, k, 2 * b));
            check(dqFall, expLanes(fmt, page, k, 2 * b + 1));
            check({11'h000, dbiOutN, dqOeN, dqsOeN, dqsRise, dqsFall}, 16'h0012);
            @(negedge clkLink);
        end
        check({15'h0000, dqOeN}, 16'h0001);
        repeat (2) @(negedge clkLink);
    endtask

    initial begin
        #2000000;
        $display("wrong value at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        miscompares++;
        final_report;
    end
    initial begin
        miscompares = 0;
        compares = 0;
        rst_n = 1'b0;
        lat = 3;
        readLatency = 6'h03;
        parityLog = 32'h0;
        modeMirror = 32'h0;
        activateLimit = 4'h0;
        pat = '{8'h55, 8'h33, 8'h0f, 8'h00};
        void'($urandom(32'h0291));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        repeat (20) @(negedge clkLink);
        check({15'h0000, trainingMode}, 16'h0000);
        ctrl.writeLoc(2'h1, 8'hc3);
        ctrl.readLoc(2'h0);
        repeat (lat) @(negedge clkLink);
        check({15'h0000, dqOeN}, 16'h0001);
        ctrl.setMode(TRR_FMT_SERIAL, 1'b1, 2'h0);
        check({15'h0000, trainingMode}, 16'h0001);
        for (int k = 0; k < 4; k++) readCheck(TRR_FMT_SERIAL, 2'h0, 2'(k));
        for (int pass = 0; pass < 7; pass++) begin
            // The first two passes pin the shortest latencies as corner cases.
            lat = (pass < 2) ? pass + 1 : 2 + $urandom_range(0, 5);
            @(negedge clk_sys);
            readLatency = 6'(lat);
            parityLog = $urandom;
            modeMirror = $urandom;
            activateLimit = (pass == 6) ? 4'h8 : 4'(pass);
            repeat (20) @(negedge clkLink);
            for (int pg = 1; pg < 4; pg++) begin
                ctrl.setMode(TRR_FMT_SERIAL, 1'b1, 2'(pg));
                ctrl.writeLoc(2'(pass), ~pat[2'(pass)]);
                // Page 1 is compared whole; the bits a controller may ignore are ours to set.
                for (int k = 0; k < 4; k++) readCheck(TRR_FMT_SERIAL, 2'(pg), 2'(k));
            end
            for (int f = 0; f < 3; f++) begin
                ctrl.setMode(2'(f), 1'b1, 2'h0);
                for (int k = 0; k < 4; k++) readCheck(2'(f), 2'h0, 2'(k));
            end
            repeat (4) begin
                loc = 2'($urandom);
                d = 8'($urandom);
                ctrl.writeLoc(loc, d);
                pat[loc] = d;
            end
        end
        for (int k = 0; k < 4; k++) readCheck(TRR_FMT_STAGGERED, 2'h0, 2'(k));
        final_report;
    end
endmodule // test_training_register_readout
